// >>> byte_move_rotate_decoder.sv
`timescale 1ns/1ps
`include "exec_regs.svh"

module byte_move_rotate_decoder
   import exec_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [13:0] instr,
   input  wire logic        instr_valid,
   input  wire logic [7:0]  file_rdata,
   input  wire logic [12:0] top_of_stack,
   input  wire logic        wake,
   output logic             instr_ready,
   output logic [6:0]       file_addr,
   output logic             file_rd,
   output logic             file_we,
   output logic [7:0]       file_wdata,
   output logic [7:0]       acc,
   output flags_s           flags,
   output logic [7:0]       option_reg,
   output logic [7:0]       interrupt_control_register,
   output logic             timeout_flag,
   output logic             powerdown_flag,
   output logic             watchdog_clear,
   output logic             stack_pop,
   output logic [12:0]      program_counter,
   output logic             osc_stop
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   phase_e     phase_r;
   decoded_s   cur_r;
   logic       second_r;
   logic       sleep_r;
   logic [7:0] operand_r;
   logic [7:0] result_r;
   flags_s     res_flags_r;

   decoded_s   dec;

   op_decoder u_dec (
      .instr (instr),
      .dec   (dec)
   );

   function automatic logic [8:0] sub_lit(input logic [7:0] k, input logic [7:0] w);
      sub_lit = {1'b0, k} + {1'b0, ~w} + 9'h001;
   endfunction

   // ----------------------------------------
   // process phase arithmetic
   // ----------------------------------------
   wire logic [8:0] diff     = sub_lit(cur_r.lit, acc);
   wire logic [4:0] low_diff = {1'b0, cur_r.lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
   wire logic [7:0] rl_val   = {operand_r[6:0], flags.carry};
   wire logic [7:0] rr_val   = {flags.carry, operand_r[7:1]};
   wire logic is_rot   = (cur_r.op == op_rotate_left_carry) || (cur_r.op == op_rotate_right_carry);
   wire logic to_file  = ((cur_r.op == op_copy_file_register) || is_rot) && cur_r.dest_file;
   wire logic needs_rd = (cur_r.op == op_copy_file_register) || is_rot || (cur_r.op == op_store_acc_to_file);
   wire logic [7:0] proc_val =
      (cur_r.op == op_rotate_left_carry)  ? rl_val :
      (cur_r.op == op_rotate_right_carry) ? rr_val :
      (cur_r.op == op_literal_minus_acc)  ? diff[7:0] :
      (cur_r.op == op_load_literal_to_acc) ? cur_r.lit :
      (cur_r.op == op_store_acc_to_file)  ? acc : operand_r;
   wire flags_s proc_flags =
      (cur_r.op == op_rotate_left_carry)  ? flags_s'{operand_r[7], flags.half_carry_flag, flags.zero} :
      (cur_r.op == op_rotate_right_carry) ? flags_s'{operand_r[0], flags.half_carry_flag, flags.zero} :
      (cur_r.op == op_literal_minus_acc)  ? flags_s'{diff[8], low_diff[4], diff[7:0] == 8'h00} :
      (cur_r.op == op_copy_file_register) ? flags_s'{flags.carry, flags.half_carry_flag, operand_r == 8'h00} :
                                            flags;
   wire logic at_write = (phase_r == ph_write) && !second_r;

   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   // four phase walk
   wire phase_e phase_nxt =
      (phase_r == ph_decode)  ? ph_read :
      (phase_r == ph_read)    ? ph_process :
      (phase_r == ph_process) ? ph_write : ph_decode;
   wire logic run = !sleep_r;
   wire logic second_nxt = at_write && (cur_r.op == op_interrupt_return);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase_r  <= ph_decode;
         second_r <= 1'b0;
         cur_r    <= '0;
      end else if (run) begin
         phase_r <= phase_nxt;
         if (phase_r == ph_write) begin
            second_r <= second_nxt;
         end
         if (phase_r == ph_write && !second_nxt) begin
            cur_r <= instr_valid ? dec : decoded_s'{op_idle_instruction, 8'h00, 7'h00, 1'b0};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         operand_r   <= 8'h00;
         result_r    <= 8'h00;
         res_flags_r <= '0;
      end else begin
         if (phase_r == ph_read && !second_r) begin
            operand_r <= file_rdata;
         end
         if (phase_r == ph_process && !second_r) begin
            result_r    <= proc_val;
            res_flags_r <= proc_flags;
         end
      end
   end

   // ----------------------------------------
   // architectural writes
   // ----------------------------------------
   wire logic acc_wr = at_write && (
      (cur_r.op == op_load_literal_to_acc) || (cur_r.op == op_literal_minus_acc) ||
      (((cur_r.op == op_copy_file_register) || is_rot) && !cur_r.dest_file));
   wire logic flag_wr = at_write && ((cur_r.op == op_copy_file_register) || is_rot ||
                                     (cur_r.op == op_literal_minus_acc));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         acc   <= `ACC_RST;
         flags <= '0;
      end else begin
         if (acc_wr) begin
            acc <= result_r;
         end
         if (flag_wr) begin
            flags <= res_flags_r;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         file_we    <= 1'b0;
         file_wdata <= 8'h00;
         file_addr  <= 7'h00;
         file_rd    <= 1'b0;
      end else begin
         file_addr <= (phase_r == ph_write) ? dec.faddr : cur_r.faddr;
         file_rd   <= (phase_r == ph_decode) && needs_rd && !second_r && run;
         file_we    <= (phase_r == ph_process) && !second_r && run &&
                       (to_file || (cur_r.op == op_store_acc_to_file));
         file_wdata <= proc_val;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         option_reg                 <= `OPTION_RST;
         interrupt_control_register <= `INTCTL_RST;
         stack_pop                  <= 1'b0;
         program_counter            <= 13'h0000;
      end else begin
         stack_pop <= 1'b0;
         if (at_write && cur_r.op == op_option_load) begin
            option_reg <= acc;
         end
         if (at_write && cur_r.op == op_interrupt_return) begin
            interrupt_control_register[`GIE_BIT] <= 1'b1;
            program_counter                      <= top_of_stack;
            stack_pop                            <= 1'b1;
         end else if (phase_r == ph_write && run && !second_r) begin
            program_counter <= program_counter + 13'h0001;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b1;
         watchdog_clear <= 1'b0;
         sleep_r        <= 1'b0;
         osc_stop       <= 1'b0;
         instr_ready    <= 1'b0;
      end else begin
         watchdog_clear <= 1'b0;
         // ready only in a write phase whose closing edge takes the next word
         instr_ready    <= (phase_r == ph_process) && run &&
                           (second_r || (cur_r.op != op_interrupt_return));
         if (at_write && cur_r.op == op_halt) begin
            watchdog_clear <= 1'b1;
            timeout_flag   <= 1'b1;
            powerdown_flag <= 1'b0;
         end
         if (at_write && cur_r.op == op_halt) begin
            sleep_r  <= 1'b1;
            osc_stop <= 1'b1;
         end else if (wake) begin
            sleep_r  <= 1'b0;
            osc_stop <= 1'b0;
         end
      end
   end

endmodule

// >>> exec_checker_assertions.sv
`timescale 1ns/1ps
module exec_checker
   import exec_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        instr_ready,
   input wire logic        file_rd,
   input wire logic        file_we,
   input wire logic [7:0]  acc,
   input wire logic [7:0]  option_reg,
   input wire logic [7:0]  interrupt_control_register,
   input wire logic        timeout_flag,
   input wire logic        powerdown_flag,
   input wire logic        watchdog_clear,
   input wire logic        stack_pop,
   input wire logic [12:0] program_counter,
   input wire logic        osc_stop
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence quiet3;
      (!file_rd && !file_we && !stack_pop) [*3];
   endsequence
   sequence asleep2;
      osc_stop ##1 osc_stop;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   chk_write_in_phase: assert property (file_we |-> instr_ready)
      else $error("file write outside write phase");
   chk_update_at_write: assert property (($changed(acc) || $changed(option_reg)) |-> $past(instr_ready))
      else $error("register changed outside write phase");
   chk_return_second_idle: assert property (stack_pop |=> quiet3)
      else $error("activity in second return cycle");
   chk_enable_from_return: assert property ($rose(interrupt_control_register[7]) |-> stack_pop || $past(stack_pop))
      else $error("enable set without stack pop");
   chk_halt_flags_set: assert property (watchdog_clear |-> timeout_flag && !powerdown_flag)
      else $error("halt flags wrong at watchdog clear");
   chk_watchdog_pulse: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear longer than one cycle");
   chk_sleep_no_work: assert property (osc_stop |-> !file_we && !stack_pop)
      else $error("activity while asleep");
   chk_sleep_pc_hold: assert property (asleep2 |-> $stable(program_counter))
      else $error("program counter moved while asleep");
endmodule

// >>> exec_pkg.sv
package exec_pkg;

   typedef enum logic [3:0] {
      op_idle_instruction      = 4'h0,
      op_load_literal_to_acc   = 4'h1,
      op_copy_file_register    = 4'h2,
      op_store_acc_to_file     = 4'h3,
      op_interrupt_return      = 4'h4,
      op_option_load           = 4'h5,
      op_rotate_left_carry     = 4'h6,
      op_rotate_right_carry    = 4'h7,
      op_halt                  = 4'h8,
      op_literal_minus_acc     = 4'h9,
      op_unsupported           = 4'hF
   } op_e;

   typedef enum logic [1:0] {
      ph_decode  = 2'b00,
      ph_read    = 2'b01,
      ph_process = 2'b11,
      ph_write   = 2'b10
   } phase_e;

   typedef struct packed {
      op_e        op;
      logic [7:0] lit;
      logic [6:0] faddr;
      logic       dest_file;
   } decoded_s;

   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } flags_s;

endpackage

// >>> exec_regs.svh
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// ----------------------------------------
// opcode fields, register bits, reset values and phase timing
// ----------------------------------------
`define OP_W          14
`define LIT_HI        7
`define FADDR_HI      6
`define DEST_BIT      7
`define GIE_BIT       7
`define ACC_RST       8'h00
`define OPTION_RST    8'hFF
`define INTCTL_RST    8'h00
`define WDT_RST       8'h00
`define PHASE_TIME_NS 10
`define CLK_PERIOD_NS 10
`define PHASE_CYC     ((`PHASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> op_decoder.sv
`timescale 1ns/1ps
`include "exec_regs.svh"

module op_decoder
   import exec_pkg::*;
(
   input  wire logic [13:0] instr,
   output decoded_s         dec
);

   wire logic [5:0] top6 = instr[13:8];
   wire logic [7:0] low8 = instr[7:0];
   wire logic is_lit_mov = (instr[13:10] == 4'hC);
   wire logic is_sub     = (instr[13:9] == 5'h1E);
   wire logic is_sys     = (top6 == 6'h00) && !instr[7];
   // ----------------------------------------
   // opcode classification
   // ----------------------------------------
   wire op_e op_sel =
      is_lit_mov                                  ? op_load_literal_to_acc :
      is_sub                                      ? op_literal_minus_acc   :
      (top6 == 6'h08)                             ? op_copy_file_register  :
      (top6 == 6'h0D)                             ? op_rotate_left_carry   :
      (top6 == 6'h0C)                             ? op_rotate_right_carry  :
      (top6 == 6'h00 && instr[7])                 ? op_store_acc_to_file   :
      (is_sys && low8 == 8'h09)                   ? op_interrupt_return    :
      (is_sys && low8 == 8'h62)                   ? op_option_load         :
      (is_sys && low8 == 8'h63)                   ? op_halt                :
      (is_sys && instr[4:0] == 5'h00)             ? op_idle_instruction    :
                                                    op_unsupported;

   assign dec.faddr     = instr[`FADDR_HI:0];
   assign dec.dest_file = instr[`DEST_BIT];
   assign dec.lit       = instr[`LIT_HI:0];
   assign dec.op        = op_sel;

endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   import exec_pkg::*;
   logic        clock = 0, reset = 1, instr_valid = 0, wake = 0;
   logic [13:0] instr = 14'h0000;
   logic [7:0]  file_rdata = 8'h00;
   logic [12:0] top_of_stack = 13'h0000;
   logic        instr_ready, file_rd, file_we, timeout_flag, powerdown_flag, watchdog_clear, stack_pop, osc_stop;
   logic [6:0]  file_addr, last_addr;
   logic [7:0]  file_wdata, acc, option_reg, interrupt_control_register, last_wdata, exp_acc = 8'h00;
   flags_s      flags;
   logic [12:0] program_counter, pc0;
   logic        exp_c = 0, exp_dc = 0, exp_z = 0;
   int          miscompares = 0, total_checks = 0, cycles = 0, we_cnt = 0, pop_cnt = 0, wdc_cnt = 0, n0;
   int          rd_cnt = 0;
   byte_move_rotate_decoder byte_move_rotate_decoder_i (.clock, .reset, .instr, .instr_valid, .file_rdata,
      .top_of_stack, .wake, .instr_ready, .file_addr, .file_rd, .file_we, .file_wdata, .acc, .flags, .option_reg,
      .interrupt_control_register, .timeout_flag, .powerdown_flag, .watchdog_clear, .stack_pop, .program_counter,
      .osc_stop);
   always #5 clock = ~clock;
   // ----------------------------------------
   // monitors and tasks
   // ----------------------------------------
   always @(posedge clock) begin
      cycles++;
      if (file_we === 1'b1) begin
         we_cnt++;
         last_wdata <= file_wdata;
         last_addr <= file_addr;
      end
      if (stack_pop === 1'b1) pop_cnt++;
      if (file_rd === 1'b1) rd_cnt++;
      if (watchdog_clear === 1'b1) wdc_cnt++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [10:0] sub_exp(input logic [7:0] k, input logic [7:0] w);
      return {k >= w, k[3:0] >= w[3:0], k == w, 8'(k - w)};
   endfunction
   task automatic run(input logic [13:0] w, input logic [7:0] fd);
      int n;
      n = 0;
      @(posedge clock);
      instr <= w;
      instr_valid <= 1;
      file_rdata <= fd;
      do begin
         @(negedge clock);
         n++;
      end while (instr_ready !== 1'b1 && n < 40);
      chk("ready", 16'(n < 40), 16'h0001);
      @(posedge clock);
      instr_valid <= 0;
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic do_op(input int kind, input logic [7:0] k, input logic [6:0] f, input logic d, input logic [7:0] fd);
      logic [13:0] w;
      logic [10:0] s;
      logic [7:0]  res;
      logic        tofile;
      int          we0;
      int          rd0;
      we0 = we_cnt;
      rd0 = rd_cnt;
      tofile = d;
      s = sub_exp(k, exp_acc);
      case (kind)
         0: begin w = {6'h30, k}; res = k; tofile = 0; end
         1: begin w = {6'h08, d, f}; res = fd; exp_z = (fd == 8'h00); end
         2: begin w = {6'h3C, k}; res = s[7:0]; tofile = 0; {exp_c, exp_dc, exp_z} = s[10:8]; end
         3: begin w = {6'h0D, d, f}; res = {fd[6:0], exp_c}; exp_c = fd[7]; end
         4: begin w = {6'h0C, d, f}; res = {exp_c, fd[7:1]}; exp_c = fd[0]; end
         default: begin w = {7'h01, f}; res = exp_acc; tofile = 1; end
      endcase
      run(w, fd);
      if (!tofile) exp_acc = res;
      chk("write count", 16'(we_cnt - we0), 16'(tofile));
      chk("read count", 16'(rd_cnt - rd0), 16'(kind != 0 && kind != 2));
      if (tofile) chk("file data", {1'b0, last_addr, last_wdata}, {1'b0, f, res});
      chk("acc", acc, exp_acc);
      chk("flags", flags, {exp_c, exp_dc, exp_z});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(96445));
      repeat (4) @(posedge clock);
      reset <= 0;
      do_op(0, 8'h5A, 7'h00, 0, 8'h00);
      do_op(0, 8'h01, 7'h00, 0, 8'h00);
      do_op(2, 8'h02, 7'h00, 0, 8'h00);
      do_op(0, 8'h02, 7'h00, 0, 8'h00);
      do_op(2, 8'h02, 7'h00, 0, 8'h00);
      do_op(0, 8'h03, 7'h00, 0, 8'h00);
      do_op(2, 8'h02, 7'h00, 0, 8'h00);
      do_op(1, 8'h00, 7'h7F, 1, 8'h00);
      do_op(3, 8'h00, 7'h11, 1, 8'h80);
      do_op(4, 8'h00, 7'h22, 0, 8'h01);
      $display("done: corner");
      repeat (80) do_op(int'($urandom_range(5)), 8'($urandom), 7'($urandom), 1'($urandom), 8'($urandom));
      $display("done: random");
      run(14'h0062, 8'h00);
      chk("option", option_reg, exp_acc);
      chk("flags", flags, {exp_c, exp_dc, exp_z});
      pc0 = program_counter;
      run(14'h0000, 8'h00);
      chk("pc", program_counter, 13'(pc0 + 13'h0002));
      run({6'h04, 1'b0, 7'h20}, 8'hFF);
      chk("acc", acc, exp_acc);
      $display("done: option idle");
      @(posedge clock);
      top_of_stack <= 13'($urandom);
      n0 = pop_cnt;
      run(14'h0009, 8'h00);
      chk("pc", program_counter, top_of_stack);
      chk("enable", interrupt_control_register[7], 1'b1);
      @(negedge clock);
      chk("pops", 16'(pop_cnt - n0), 16'h0001);
      $display("done: return");
      n0 = wdc_cnt;
      run(14'h0063, 8'h00);
      repeat (3) @(negedge clock);
      chk("halt", {osc_stop, timeout_flag, powerdown_flag}, 3'h6);
      chk("wdog", 16'(wdc_cnt - n0), 16'h0001);
      @(posedge clock);
      instr <= {6'h30, ~exp_acc};
      instr_valid <= 1;
      repeat (12) @(negedge clock);
      chk("asleep acc", acc, exp_acc);
      @(posedge clock);
      instr_valid <= 0;
      wake <= 1;
      for (int i = 0; i < 20 && osc_stop !== 1'b0; i++) @(negedge clock);
      chk("woken", osc_stop, 1'b0);
      @(posedge clock);
      wake <= 0;
      do_op(0, 8'hC3, 7'h00, 0, 8'h00);
      $display("done: halt");
      conclude();
   end
endmodule
bind byte_move_rotate_decoder exec_checker exec_checker_i (.clock, .reset, .instr_ready, .file_rd, .file_we, .acc,
   .option_reg, .interrupt_control_register, .timeout_flag, .powerdown_flag, .watchdog_clear, .stack_pop,
   .program_counter, .osc_stop);
